/* rtl/self_test_pkg.sv */
package self_test_pkg;
    localparam int unsigned CLK_HZ       = 40000000;
    localparam int unsigned BELL_MS      = 250;
    localparam int unsigned BELL_CYC     = CLK_HZ / 1000 * BELL_MS;
    localparam int unsigned FLASH_MS     = 500;
    localparam int unsigned FLASH_CYC    = CLK_HZ / 1000 * FLASH_MS;
    localparam int unsigned KBD_WAIT_MS  = 100;
    localparam int unsigned KBD_WAIT_CYC = CLK_HZ / 1000 * KBD_WAIT_MS;
    localparam int unsigned MEM_AW       = 10;
    localparam int unsigned ROM_N        = 4;

    localparam logic [31:0] ADDR_CTRL    = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS  = 32'h0000_0004;
    localparam logic [31:0] ADDR_FAULTS  = 32'h0000_0008;
    localparam logic [31:0] ADDR_GFX     = 32'h0000_000c;
    localparam int unsigned CTRL_RUN_BIT  = 0;
    localparam int unsigned CTRL_CONT_BIT = 1;
    localparam int unsigned CTRL_ANSI_BIT = 2;
    localparam logic [7:0]  CODE_BASE     = 8'h30;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_MRAM  = 3'b001,
        ST_XRAM  = 3'b010,
        ST_NVCK  = 3'b011,
        ST_ROM   = 3'b100,
        ST_KBD   = 3'b101,
        ST_DONE  = 3'b110,
        ST_HALT  = 3'b111
    } phase_t;

    typedef struct packed {
        logic xram;
        logic settings;
        logic kbd;
        logic mram;
        logic [3:0] rom;
    } faults_t;

    typedef struct packed {
        logic offline;
        logic host_port;
        logic internal_link;
        logic printer_port;
        logic bitmap;
        logic vector_draw;
    } gfx_faults_t;
endpackage

/* rtl/terminal_self_test_sequencer.sv */
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module terminal_self_test_sequencer (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [31:0]                      paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    output logic                                  ram_we,
    output logic      [self_test_pkg::MEM_AW-1:0] ram_addr,
    output logic                                  ram_wdata,
    input  wire logic                             ram_rdata,
    input  wire logic                             xram_rdata,
    input  wire logic                             xram_present,
    input  wire logic                             menu_reset_key,
    output logic                                  sum_req,
    output logic      [2:0]                       sum_sel,
    input  wire logic                             sum_done,
    input  wire logic                             sum_match,
    input  wire logic                             end_of_scan,
    input  wire logic                             local_state,
    output logic      [3:0]                       indicator_lamps,
    output logic                                  kbd_bell,
    output logic      [7:0]                       error_char,
    output logic                                  error_char_valid,
    output logic                                  screen_invert,
    output logic                                  basic_text_only,
    output logic                                  use_factory_defaults,
    output logic                                  setup_locked,
    output logic                                  force_online,
    output logic                                  printer_blocked,
    output logic                                  gfx_only,
    output logic      [6:0]                       gfx_msg
);
    // Pin inputs pass two flip-flops; memory and checksum inputs are same-clock
    typedef struct packed {
        logic [1:0] key_s;
        logic [1:0] eos_s;
        logic [1:0] pres_s;
        logic [1:0] loc_s;
        logic       key_prev;
        self_test_pkg::phase_t phase;
        logic [self_test_pkg::MEM_AW-1:0] addr;
        logic [1:0] pass;
        logic [2:0] rom_idx;
        logic       req;
        logic [31:0] cnt;
        logic [31:0] flash_cnt;
        logic       flash;
        logic       cont;
        logic       ansi;
        logic       started;
        self_test_pkg::faults_t f;
        self_test_pkg::gfx_faults_t g;
        logic       ran;
    } state_t;

    state_t s_q, s_d;
    logic   wr_en;
    logic   rd_bit;
    logic   any_fault;
    logic   key_edge;
    logic [2:0] weight;

    assign wr_en    = psel && penable && pwrite;
    assign key_edge = s_q.key_s[1] && !s_q.key_prev;
    assign rd_bit   = (s_q.phase == self_test_pkg::ST_XRAM) ? xram_rdata : ram_rdata;
    assign weight   = {s_q.f.kbd, s_q.f.settings, s_q.f.xram};
    assign any_fault = |{s_q.f.xram, s_q.f.settings, s_q.f.kbd, s_q.f.mram, s_q.f.rom};

    always_comb begin
        s_d = s_q;
        s_d.key_s    = {s_q.key_s[0], menu_reset_key};
        s_d.eos_s    = {s_q.eos_s[0], end_of_scan};
        s_d.pres_s   = {s_q.pres_s[0], xram_present};
        s_d.loc_s    = {s_q.loc_s[0], local_state};
        s_d.key_prev = s_q.key_s[1];
        s_d.req      = 1'b0;
        if (wr_en && paddr == self_test_pkg::ADDR_CTRL) begin
            s_d.ansi = pwdata[self_test_pkg::CTRL_ANSI_BIT];
        end
        if (wr_en && paddr == self_test_pkg::ADDR_GFX) begin
            s_d.g = s_q.g | pwdata[5:0];
        end
        s_d.g.offline = s_q.loc_s[1];
        unique case (s_q.phase)
            self_test_pkg::ST_IDLE, self_test_pkg::ST_DONE: begin
                if (!s_q.started || key_edge
                    || (wr_en && paddr == self_test_pkg::ADDR_CTRL && s_q.ansi
                        && pwdata[self_test_pkg::CTRL_RUN_BIT])) begin
                    s_d.started = 1'b1;
                    s_d.cont    = wr_en && pwdata[self_test_pkg::CTRL_CONT_BIT] && s_q.started;
                    s_d.f       = '0;
                    s_d.ran     = 1'b0;
                    s_d.phase   = self_test_pkg::ST_MRAM;
                    s_d.addr    = '0;
                    s_d.pass    = '0;
                end
            end
            self_test_pkg::ST_MRAM, self_test_pkg::ST_XRAM: begin
                // pass 0/2 write, pass 1/3 check; pattern 1 then 0
                if (s_q.pass[0] && rd_bit != !s_q.pass[1]) begin
                    if (s_q.phase == self_test_pkg::ST_MRAM) begin
                        s_d.f.mram = 1'b1;
                        s_d.phase  = self_test_pkg::ST_HALT;
                    end else begin
                        // Extension fault is not fatal: drop to the settings check
                        s_d.f.xram  = 1'b1;
                        s_d.phase   = self_test_pkg::ST_NVCK;
                        s_d.req     = 1'b1;
                        s_d.rom_idx = '0;
                    end
                end else if (&s_q.addr) begin
                    s_d.addr = '0;
                    s_d.pass = s_q.pass + 2'd1;
                    if (s_q.pass == 2'd3) begin
                        if (s_q.phase == self_test_pkg::ST_MRAM && s_q.pres_s[1]) begin
                            s_d.phase = self_test_pkg::ST_XRAM;
                        end else begin
                            s_d.phase   = self_test_pkg::ST_NVCK;
                            s_d.req     = 1'b1;
                            s_d.rom_idx = '0;
                        end
                    end
                end else begin
                    s_d.addr = s_q.addr + 1'b1;
                end
            end
            self_test_pkg::ST_NVCK: begin
                if (sum_done) begin
                    // Settings fault selects defaults, the error digit and the done/halt bell; the run goes on
                    if (!sum_match) begin
                        s_d.f.settings = 1'b1;
                    end
                    s_d.phase   = self_test_pkg::ST_ROM;
                    s_d.req     = 1'b1;
                    s_d.rom_idx = 3'd1;
                end
            end
            self_test_pkg::ST_ROM: begin
                if (sum_done) begin
                    if (!sum_match) begin
                        s_d.f.rom = {1'b0, s_q.rom_idx};
                        s_d.phase = self_test_pkg::ST_HALT;
                    end else if (s_q.rom_idx == 3'(self_test_pkg::ROM_N)) begin
                        s_d.phase = self_test_pkg::ST_KBD;
                        s_d.cnt   = '0;
                    end else begin
                        s_d.rom_idx = s_q.rom_idx + 3'd1;
                        s_d.req     = 1'b1;
                    end
                end
            end
            self_test_pkg::ST_KBD: begin
                s_d.cnt = s_q.cnt + 32'd1;
                if (s_q.eos_s[1] && s_q.cnt >= self_test_pkg::BELL_CYC) begin
                    s_d.phase = self_test_pkg::ST_DONE;
                    s_d.ran   = 1'b1;
                end else if (s_q.cnt >= self_test_pkg::BELL_CYC + self_test_pkg::KBD_WAIT_CYC) begin
                    s_d.f.kbd = 1'b1;
                    s_d.phase = self_test_pkg::ST_DONE;
                    s_d.ran   = 1'b1;
                end
                if (s_d.phase == self_test_pkg::ST_DONE && s_q.cont && !s_d.f.kbd) begin
                    s_d.phase = self_test_pkg::ST_MRAM;
                    s_d.addr  = '0;
                    s_d.pass  = '0;
                end
            end
            self_test_pkg::ST_HALT: begin
                if (key_edge) begin
                    s_d.started = 1'b0;
                    s_d.phase   = self_test_pkg::ST_IDLE;
                end
            end
            default: s_d.phase = self_test_pkg::ST_HALT;
        endcase
        // Once-per-second white-black-white alarm in continuous mode
        if (s_q.cont && (s_q.phase == self_test_pkg::ST_HALT || s_q.f.kbd)) begin
            if (s_q.flash_cnt >= self_test_pkg::FLASH_CYC - 1) begin
                s_d.flash_cnt = '0;
                s_d.flash     = !s_q.flash;
            end else begin
                s_d.flash_cnt = s_q.flash_cnt + 32'd1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ram_we    = !s_q.pass[0] && (s_q.phase == self_test_pkg::ST_MRAM
                                        || s_q.phase == self_test_pkg::ST_XRAM);
    assign ram_addr  = s_q.addr;
    assign ram_wdata = !s_q.pass[1];
    assign sum_req   = s_q.req;
    assign sum_sel   = s_q.rom_idx;
    assign kbd_bell  = (s_q.phase == self_test_pkg::ST_KBD) && s_q.cnt < self_test_pkg::BELL_CYC
                       || (s_q.f.settings && (s_q.phase == self_test_pkg::ST_HALT
                                              || s_q.phase == self_test_pkg::ST_DONE));

    always_comb begin
        if (s_q.phase == self_test_pkg::ST_KBD) begin
            indicator_lamps = 4'hf;
        end else if (s_q.f.mram) begin
            indicator_lamps = 4'h5;
        end else begin
            indicator_lamps = s_q.f.rom;
        end
    end

    assign error_char       = self_test_pkg::CODE_BASE + {5'h00, weight};
    assign error_char_valid = weight != 3'h0;
    assign screen_invert    = s_q.flash;
    assign basic_text_only      = s_q.f.xram;
    assign use_factory_defaults = s_q.f.settings;
    assign setup_locked = s_q.f.kbd;
    assign force_online = s_q.f.kbd && !s_q.f.settings && !s_q.f.xram;
    assign printer_blocked = s_q.g.printer_port;
    assign gfx_only = s_q.g.offline || s_q.g.internal_link;
    // Message bits: ok, offline, host, link, printer, bitmap, vector
    assign gfx_msg = {s_q.ran && !any_fault && s_q.g == '0, s_q.g};

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(paddr == self_test_pkg::ADDR_CTRL || paddr == self_test_pkg::ADDR_STATUS
                     || paddr == self_test_pkg::ADDR_FAULTS || paddr == self_test_pkg::ADDR_GFX);
    always_comb begin
        unique case (paddr)
            self_test_pkg::ADDR_CTRL:   prdata = {29'h0, s_q.ansi, s_q.cont, 1'b0};
            self_test_pkg::ADDR_STATUS: prdata = {28'h0, s_q.ran, s_q.phase};
            self_test_pkg::ADDR_FAULTS: prdata = {24'h0, s_q.f};
            self_test_pkg::ADDR_GFX:    prdata = {26'h0, s_q.g};
            default:                    prdata = 32'h0;
        endcase
    end

    chk_halt_holds: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.phase == self_test_pkg::ST_HALT && !key_edge |=> s_q.phase == self_test_pkg::ST_HALT)
        else $error("halt left without reset key");
    chk_flags_held: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.f.settings && s_q.phase != self_test_pkg::ST_IDLE && s_q.phase != self_test_pkg::ST_DONE
        |=> s_q.f.settings) else $error("settings fault dropped");
    chk_defaults_mode: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.f.settings |-> use_factory_defaults) else $error("defaults not selected");
    chk_mram_lamps: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.f.mram && s_q.phase == self_test_pkg::ST_HALT |-> indicator_lamps == 4'h5)
        else $error("wrong main ram lamps");

    // Step sequences for the run start and the memory and checksum phases
    sequence s_mram_miss;
        s_q.phase == self_test_pkg::ST_MRAM && s_q.pass[0] && rd_bit != !s_q.pass[1];
    endsequence

    sequence s_xram_miss;
        s_q.phase == self_test_pkg::ST_XRAM && s_q.pass[0] && rd_bit != !s_q.pass[1];
    endsequence

    sequence s_sum_miss;
        sum_done && !sum_match;
    endsequence

    sequence s_last_rom_ok;
        s_q.phase == self_test_pkg::ST_ROM && sum_done && sum_match
            && s_q.rom_idx == 3'(self_test_pkg::ROM_N);
    endsequence

    sequence s_run_start;
        (s_q.phase == self_test_pkg::ST_IDLE || s_q.phase == self_test_pkg::ST_DONE)
            ##1 s_q.phase == self_test_pkg::ST_MRAM;
    endsequence

    chk_mram_stop: assert property (@(posedge pclk) disable iff (!presetn)
        s_mram_miss |=> s_q.phase == self_test_pkg::ST_HALT && s_q.f.mram)
        else $error("main ram fault did not halt");

    chk_xram_skip: assert property (@(posedge pclk) disable iff (!presetn)
        s_xram_miss |=> s_q.phase == self_test_pkg::ST_NVCK && s_q.f.xram && sum_req)
        else $error("extension fault not passed on");

    chk_settings_miss: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.phase == self_test_pkg::ST_NVCK ##0 s_sum_miss |=> s_q.f.settings && s_q.phase == self_test_pkg::ST_ROM)
        else $error("settings fault not recorded");

    chk_rom_miss: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.phase == self_test_pkg::ST_ROM ##0 s_sum_miss
        |=> s_q.phase == self_test_pkg::ST_HALT && s_q.f.rom == {1'b0, $past(s_q.rom_idx)})
        else $error("rom fault code wrong");

    chk_rom_to_kbd: assert property (@(posedge pclk) disable iff (!presetn)
        s_last_rom_ok |=> s_q.phase == self_test_pkg::ST_KBD && s_q.cnt == 32'd0)
        else $error("keyboard check not next");

    chk_start_clear: assert property (@(posedge pclk) disable iff (!presetn)
        s_run_start |-> s_q.f == '0 && !s_q.ran)
        else $error("faults not cleared at start");

    chk_kbd_lamps: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.phase == self_test_pkg::ST_KBD |-> indicator_lamps == 4'hf)
        else $error("lamps not all on");

    chk_kbd_bell: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.phase == self_test_pkg::ST_KBD && s_q.cnt < self_test_pkg::BELL_CYC |-> kbd_bell)
        else $error("bell silent during keyboard check");

    chk_text_only: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.f.xram |-> basic_text_only)
        else $error("basic text mode not selected");

    chk_setup_lock: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.f.kbd |-> setup_locked)
        else $error("setup not locked");

    chk_online_only: assert property (@(posedge pclk) disable iff (!presetn)
        force_online |-> s_q.f.kbd && !use_factory_defaults && !basic_text_only)
        else $error("on-line without lone keyboard fault");

    chk_error_code: assert property (@(posedge pclk) disable iff (!presetn)
        error_char_valid |-> error_char[7:3] == 5'h06 && error_char[2:0] != 3'h0)
        else $error("error digit out of range");

    chk_flash_cont: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.cont |=> $stable(screen_invert))
        else $error("screen flashed outside continuous run");

    chk_halt_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.phase == self_test_pkg::ST_HALT |-> !ram_we && !sum_req)
        else $error("activity while halted");

    chk_ok_msg: assert property (@(posedge pclk) disable iff (!presetn)
        gfx_msg[6] |-> gfx_msg[5:0] == 6'h00 && !error_char_valid)
        else $error("all-good shown with a fault");
endmodule

/* test/keyboard_memory_model.sv */
`timescale 1ns/1ps
// Far side: bit memories, checksum engine and keyboard, with injectable faults
module keyboard_memory_model (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             ram_we,
    input  wire logic [self_test_pkg::MEM_AW-1:0] ram_addr,
    input  wire logic                             ram_wdata,
    output logic                                  ram_rdata,
    output logic                                  xram_rdata,
    input  wire logic                             sum_req,
    input  wire logic [2:0]                       sum_sel,
    output logic                                  sum_done,
    output logic                                  sum_match,
    input  wire logic                             kbd_bell,
    output logic                                  end_of_scan,
    input  wire logic                             ram_bad,
    input  wire logic                             xram_bad,
    input  wire logic [4:0]                       sum_bad
);
    logic       mem [2**self_test_pkg::MEM_AW];
    logic [2:0] dly;
    logic [2:0] sel_q;
    logic       bell_q;

    // One cell stuck at zero in main RAM, every cell in the extension RAM
    assign ram_rdata  = mem[ram_addr] & ~(ram_bad && ram_addr == 5);
    assign xram_rdata = mem[ram_addr] & ~xram_bad;

    always_ff @(posedge pclk) begin
        if (ram_we) mem[ram_addr] <= ram_wdata;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly         <= 3'h0;
            sel_q       <= 3'h0;
            sum_done    <= 1'b0;
            sum_match   <= 1'b0;
            bell_q      <= 1'b0;
            end_of_scan <= 1'b0;
        end else begin
            sum_done  <= (dly == 3'h1);
            // Match flag is junk outside the done cycle
            sum_match <= (dly == 3'h1) ? ~sum_bad[sel_q] : dly[0];
            if (sum_req) begin
                dly   <= 3'h4;
                sel_q <= sum_sel;
            end else if (dly != 3'h0) begin
                dly <= dly - 3'h1;
            end
            bell_q      <= kbd_bell;
            end_of_scan <= bell_q & ~kbd_bell;
        end
    end
endmodule

/* test/terminal_self_test_sequencer_bench.sv */
`timescale 1ns/1ps
module terminal_self_test_sequencer_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, ram_we, ram_wdata, ram_rdata, xram_rdata, sum_req, sum_done, sum_match;
    logic [self_test_pkg::MEM_AW-1:0] ram_addr;
    logic [2:0] sum_sel;
    logic [3:0] indicator_lamps;
    logic [7:0] error_char;
    logic [6:0] gfx_msg;
    logic xram_present = 1'b1, menu_reset_key = 1'b0, end_of_scan, local_state = 1'b0, kbd_bell;
    logic error_char_valid, screen_invert, basic_text_only, use_factory_defaults, setup_locked;
    logic force_online, printer_blocked, gfx_only, ram_bad = 1'b0, xram_bad = 1'b0;
    logic [4:0] sum_bad = 5'h0;
    logic [31:0] r;
    logic e;
    int miscompares = 0, num_checks = 0;

    terminal_self_test_sequencer terminal_self_test_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .xram_rdata(xram_rdata), .xram_present(xram_present), .menu_reset_key(menu_reset_key),
        .sum_req(sum_req), .sum_sel(sum_sel), .sum_done(sum_done), .sum_match(sum_match),
        .end_of_scan(end_of_scan), .local_state(local_state), .indicator_lamps(indicator_lamps),
        .kbd_bell(kbd_bell), .error_char(error_char), .error_char_valid(error_char_valid),
        .screen_invert(screen_invert), .basic_text_only(basic_text_only),
        .use_factory_defaults(use_factory_defaults), .setup_locked(setup_locked), .force_online(force_online),
        .printer_blocked(printer_blocked), .gfx_only(gfx_only), .gfx_msg(gfx_msg));
    keyboard_memory_model keyboard_memory_model_i (.pclk(pclk), .presetn(presetn), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .xram_rdata(xram_rdata),
        .sum_req(sum_req), .sum_sel(sum_sel), .sum_done(sum_done), .sum_match(sum_match),
        .kbd_bell(kbd_bell), .end_of_scan(end_of_scan), .ram_bad(ram_bad), .xram_bad(xram_bad),
        .sum_bad(sum_bad));

    always #12.5 pclk = ~pclk;

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Access completes at the first rising edge that sees pready high
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) begin
            miscompares++;
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic restart(input logic rb, input logic xb, input logic xp, input logic [4:0] sb);
        ram_bad <= rb; xram_bad <= xb; xram_present <= xp; sum_bad <= sb; presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic wait_phase(input logic [2:0] want);
        logic [2:0] prev;
        int n;
        prev = 3'h0;
        n = 0;
        do begin
            apb(1'b0, self_test_pkg::ADDR_STATUS, 32'h0);
            check("phase order", {31'h0, r[2:0] < prev}, 32'h0);
            prev = r[2:0];
            n++;
        end while (r[2:0] !== want && n < 4000);
        if (r[2:0] !== want) begin
            miscompares++;
            conclude();
        end
    endtask

    task automatic t_regs();
        apb(1'b1, self_test_pkg::ADDR_CTRL, 32'h4);
        apb(1'b0, self_test_pkg::ADDR_CTRL, 32'h0);
        check("ctrl", r, 32'h4);
        apb(1'b0, 32'h0000_0010, 32'h0);
        check("unmapped err", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
        apb(1'b1, self_test_pkg::ADDR_GFX, 32'h4);
        @(negedge pclk);
        check("printer", {gfx_msg[2], printer_blocked, gfx_only}, 32'h6);
        apb(1'b1, self_test_pkg::ADDR_GFX, 32'h8);
        @(negedge pclk);
        check("link", {gfx_msg[3], gfx_only, printer_blocked}, 32'h7);
        local_state <= 1'b1;
        repeat (4) @(posedge pclk);
        check("offline", {31'h0, gfx_msg[5]}, 32'h1);
        local_state <= 1'b0;
        $display("test regs done");
    endtask

    task automatic t_clean();
        restart(1'b0, 1'b0, 1'b1, 5'h0);
        wait_phase(self_test_pkg::ST_KBD);
        repeat (4) @(posedge pclk);
        check("lamps all on", {28'h0, indicator_lamps}, 32'hf);
        check("bell", {31'h0, kbd_bell}, 32'h1);
        apb(1'b0, self_test_pkg::ADDR_FAULTS, 32'h0);
        check("clean faults", r, 32'h0);
        check("modes", {use_factory_defaults, basic_text_only}, 32'h0);
        $display("test clean done");
    endtask

    task automatic t_ram();
        restart(1'b1, 1'b0, 1'b1, 5'h0);
        wait_phase(self_test_pkg::ST_HALT);
        check("ram lamps", {28'h0, indicator_lamps}, 32'h5);
        apb(1'b0, self_test_pkg::ADDR_FAULTS, 32'h0);
        check("ram fault", r, 32'h10);
        repeat (20) @(posedge pclk);
        check("halted", {ram_we, sum_req, indicator_lamps}, 32'h5);
        ram_bad <= 1'b0;
        menu_reset_key <= 1'b1;
        repeat (4) @(posedge pclk);
        menu_reset_key <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, self_test_pkg::ADDR_FAULTS, 32'h0);
        check("restart clears", r, 32'h0);
        $display("test ram done");
    endtask

    task automatic t_rom();
        for (int k = 0; k < 4; k++) begin
            restart(1'b0, 1'b0, 1'b1, 5'h2 << k);
            wait_phase(self_test_pkg::ST_HALT);
            check("rom lamps", {28'h0, indicator_lamps}, k + 1);
        end
        $display("test rom done");
    endtask

    task automatic t_modes();
        restart(1'b0, 1'b1, 1'b1, 5'h1);
        wait_phase(self_test_pkg::ST_KBD);
        apb(1'b0, self_test_pkg::ADDR_FAULTS, 32'h0);
        check("xram settings", r, 32'hc0);
        check("fallback", {use_factory_defaults, basic_text_only}, 32'h3);
        restart(1'b0, 1'b1, 1'b0, 5'h0);
        wait_phase(self_test_pkg::ST_KBD);
        apb(1'b0, self_test_pkg::ADDR_FAULTS, 32'h0);
        check("xram skipped", r, 32'h0);
        $display("test modes done");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_clean();
        t_ram();
        t_rom();
        t_modes();
        conclude();
    end
endmodule
